// *** rtl/dbd_addr_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module dbd_addr_mux
(
   input wire logic [31:0] addr,
   input wire logic col,
   input wire logic byte_port,
   input wire logic no_mux,
   output logic [31:0] pins
);
   logic [31:0] colv;

   genvar p;
   generate
      for (p = 0; p < 32; p++)
      begin : g_pin
         if (p >= 9 && p <= 16)
         begin : g_lo
            assign colv[p] = addr[17 - p];
         end
         else if (p >= 18 && p <= 25)
         begin : g_hi
            assign colv[p] = addr[p - 1];
         end
         else if (p == 17)
         begin : g_17
            assign colv[p] = byte_port ? addr[0] : addr[16];
         end
         else
         begin : g_keep
            assign colv[p] = addr[p];
         end
      end
   endgenerate

   // one scheme for every access mode; col, the no-mux option and the 8-bit port select (pin 17) steer it
   assign pins = (col && !no_mux) ? colv : addr;
endmodule // dbd_addr_mux
`default_nettype wire

// *** rtl/dbd_ctrl.sv ***
// Contract
// - port width field: 00 is 32-bit, 01 is 8-bit, 10 and 11 are 16-bit
// - page field: 00 none, 01 bursts only, 11 continuous, 10 reserved
// - upper address bits with mask bit 1 are left out of the hit compare
// - hit only when all unmasked upper bits equal the programmed base
// - write-protect set makes the bank ignore writes
// - six access-type bits; a set bit stops that type hitting the bank
// - valid bit gates decoding and resets to 0
// - modes: nonpage, burst page, continuous page, extended data-out; the EDO bit is stored but drives nothing
// - drive row strobe, column strobes, read/write line, address, termination
// - one address multiplex scheme for every access mode
// - row phase: each address pin carries the same address bit
// - column phase: pins 9..16 carry bits 8..1, pins 18..25 bits 17..24
// - column phase pin 17: bit 0 on 8-bit port, else bit 16
// - page is fixed at 512 bytes for all widths and sizes
// - no-multiplex option keeps row addresses on the bus throughout
`timescale 1ns/1ps
`default_nettype none
module dbd_ctrl
   import dbd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic BUS_REQ,
   input wire logic [31:0] BUS_ADDR,
   input wire logic BUS_WRITE,
   input wire logic [1:0] BUS_SIZE,
   input wire logic BUS_CPU_SPACE,
   input wire logic BUS_ALT_MASTER,
   input wire logic BUS_SUPERVISOR,
   input wire logic BUS_CODE,
   input wire logic BUS_NEXT_VALID,
   input wire logic [31:0] BUS_NEXT_ADDR,
   output logic BUS_TA,
   output logic [1:0] RAS_N,
   output logic [3:0] CAS_N,
   output logic DRAM_READ_WRITE_LINE,
   output logic [31:0] DRAM_ADDR
);
   import dbd_pkg::*;

   typedef struct packed {
      logic [31:0] cfg;
      logic [1:0][31:0] ac;
      logic [1:0][31:0] mk;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      dbd_state_e st;
      logic [1:0] cnt;
      logic [4:0] beats;
      logic [31:0] addr;
      logic bank;
      logic wr;
      logic col;
      logic pend;
      logic ta;
      logic [1:0] ras_n;
      logic [3:0] cas_n;
      logic rw;
      logic [31:0] pins;
   } dbd_st_s;

   dbd_st_s q;
   dbd_st_s d;

   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      unique case (a)
         OFF_CFG: reg_sel = SEL_CFG;
         OFF_AC0: reg_sel = SEL_AC0;
         OFF_MK0: reg_sel = SEL_MK0;
         OFF_AC1: reg_sel = SEL_AC1;
         OFF_MK1: reg_sel = SEL_MK1;
         OFF_STAT: reg_sel = SEL_STAT;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // bank hit with access qualification
   function automatic logic bank_hit(input logic [31:0] a, input logic [31:0] ac,
                                     input logic [31:0] mk, input logic wr);
      logic [AC_BA_HI:AC_BA_LO] diff;
      logic excl;
      diff = (a[AC_BA_HI:AC_BA_LO] ^ ac[AC_BA_HI:AC_BA_LO])
             & ~mk[AC_BA_HI:AC_BA_LO];
      if (BUS_CPU_SPACE)
         excl = mk[MK_CI];
      else if (BUS_ALT_MASTER)
         excl = mk[MK_AM];
      else if (BUS_SUPERVISOR)
         excl = BUS_CODE ? mk[MK_SC] : mk[MK_SD];
      else
         excl = BUS_CODE ? mk[MK_UC] : mk[MK_UD];
      bank_hit = mk[MK_V]
                 && (diff == '0)
                 && !excl
                 && !(wr && mk[MK_WP]);
   endfunction

   // log2 of port bytes
   function automatic logic [1:0] port_lg(input logic [1:0] ps);
      unique case (ps)
         PW_32: port_lg = 2'd2;
         PW_8: port_lg = 2'd0;
         default: port_lg = 2'd1;
      endcase
   endfunction

   // number of beats: operand bytes over port bytes, at least one
   function automatic logic [4:0] beat_cnt(input logic [1:0] sz, input logic [1:0] ps);
      logic [2:0] olg;
      logic [2:0] plg;
      unique case (sz)
         OP_LONG: olg = 3'd2;
         OP_BYTE: olg = 3'd0;
         OP_WORD: olg = 3'd1;
         default: olg = 3'd4;
      endcase
      plg = {1'b0, port_lg(ps)};
      beat_cnt = (olg > plg) ? 5'(5'd1 << (olg - plg)) : 5'd1;
   endfunction

   // reserved page encoding folds into no page mode
   function automatic logic [1:0] page_lvl(input logic [31:0] ac);
      unique case (ac[AC_PM_LO +: 2])
         PG_BURST: page_lvl = PG_BURST;
         PG_CONT: page_lvl = PG_CONT;
         default: page_lvl = PG_NONE;
      endcase
   endfunction

   logic [31:0] cur_ac;
   logic [31:0] cur_mk;
   logic [1:0] cur_ps;
   logic [1:0] cur_pm;
   logic [31:0] mux_pins;
   logic [3:0] lanes;

   assign cur_ac = q.ac[q.bank];
   assign cur_mk = q.mk[q.bank];
   assign cur_ps = cur_ac[AC_PS_LO +: 2];
   assign cur_pm = page_lvl(cur_ac);

   dbd_addr_mux u_mux
   (
      .addr(q.addr),
      .col(q.col),
      .byte_port(cur_ps == PW_8),
      .no_mux(q.cfg[CFG_NAM]),
      .pins(mux_pins)
   );

   always_comb
   begin
      unique case (cur_ps)
         PW_32: lanes = 4'b1111;
         PW_8: lanes = 4'b0001;
         default: lanes = 4'b0011;
      endcase
   end

   always_comb
   begin
      logic [2:0] sel;
      logic [31:0] rv;
      logic h0;
      logic h1;
      logic nxt_hit;
      logic hold_ok;
      logic [2:0] pb;
      d = q;
      sel = reg_sel(PADDR);
      rv = '0;
      h0 = bank_hit(BUS_ADDR, q.ac[0], q.mk[0], BUS_WRITE);
      h1 = bank_hit(BUS_ADDR, q.ac[1], q.mk[1], BUS_WRITE);
      nxt_hit = bank_hit(BUS_NEXT_ADDR, cur_ac, cur_mk, BUS_WRITE);
      // continuous page mode only: a valid next access to the same bank and 512-byte page keeps the row open
      hold_ok = (cur_pm == PG_CONT) && BUS_NEXT_VALID && nxt_hit
                && (BUS_NEXT_ADDR[31:PAGE_LSB] == q.addr[31:PAGE_LSB]);
      pb = 3'(3'd1 << port_lg(cur_ps));

      // APB: one wait cycle so read data comes from a register
      unique case (sel)
         SEL_CFG: rv = q.cfg;
         SEL_AC0: rv = q.ac[0];
         SEL_MK0: rv = q.mk[0];
         SEL_AC1: rv = q.ac[1];
         SEL_MK1: rv = q.mk[1];
         SEL_STAT: rv = {21'd0, q.beats, q.pend, q.col, q.bank, 3'(q.st)};
         default: rv = '0;
      endcase
      if (PSEL && PENABLE && !q.rdy)
      begin
         d.rdy = 1'b1;
         d.err = (sel == SEL_NONE);
         d.rdata = PWRITE ? '0 : rv;
      end
      else if (q.rdy)
      begin
         d.rdy = 1'b0;
         d.err = 1'b0;
         if (PSEL && PENABLE && PWRITE)
         begin
            unique case (sel)
               SEL_CFG: d.cfg = PWDATA & CFG_WMASK;
               SEL_AC0: d.ac[0] = PWDATA & AC_WMASK;
               SEL_MK0: d.mk[0] = PWDATA & MK_WMASK;
               SEL_AC1: d.ac[1] = PWDATA & AC_WMASK;
               SEL_MK1: d.mk[1] = PWDATA & MK_WMASK;
               default: d.cfg = q.cfg;
            endcase
         end
      end

      // access sequencer
      unique case (q.st)
         ST_IDLE:
         begin
            if (BUS_REQ && (h0 || h1))
            begin
               d.bank = h1 && !h0;
               d.addr = BUS_ADDR;
               d.wr = BUS_WRITE;
               d.beats = beat_cnt(BUS_SIZE, q.ac[h1 && !h0][AC_PS_LO +: 2]);
               d.st = ST_ROW;
               d.cnt = {1'b0, q.ac[h1 && !h0][AC_RCD]};
               d.col = 1'b0;
            end
         end
         ST_ROW:
         begin
            if (q.cnt == 2'd0)
            begin
               d.st = ST_COL;
               d.col = 1'b1;
               d.cnt = cur_ac[AC_CAS_LO +: 2];
            end
            else
               d.cnt = q.cnt - 2'd1;
         end
         ST_COL:
         begin
            if (q.cnt != 2'd0)
               d.cnt = q.cnt - 2'd1;
            else if (q.beats > 5'd1)
            begin
               d.beats = q.beats - 5'd1;
               d.addr = q.addr + {29'd0, pb};
               if (cur_pm != PG_NONE)
                  d.st = ST_GAP;
               else
               begin
                  // nonpage: each beat is its own row cycle
                  d.st = ST_PRE;
                  d.pend = 1'b1;
                  d.col = 1'b0;
                  d.cnt = cur_ac[AC_RP_LO +: 2];
               end
            end
            else if (hold_ok)
               d.st = ST_HOLD;
            else
            begin
               d.st = ST_PRE;
               d.pend = 1'b0;
               d.col = 1'b0;
               d.cnt = cur_ac[AC_RP_LO +: 2];
            end
         end
         ST_GAP:
         begin
            d.st = ST_COL;
            d.cnt = cur_ac[AC_CAS_LO +: 2];
         end
         ST_HOLD:
         begin
            if (BUS_REQ && bank_hit(BUS_ADDR, cur_ac, cur_mk, BUS_WRITE)
                && (BUS_ADDR[31:PAGE_LSB] == q.addr[31:PAGE_LSB]))
            begin
               d.addr = BUS_ADDR;
               d.wr = BUS_WRITE;
               d.beats = beat_cnt(BUS_SIZE, cur_ps);
               d.st = ST_COL;
               d.cnt = cur_ac[AC_CAS_LO +: 2];
            end
            else if (BUS_REQ || !BUS_NEXT_VALID)
            begin
               // page miss: precharge first, then run the request as a new row
               d.st = ST_PRE;
               d.col = 1'b0;
               d.cnt = cur_ac[AC_RP_LO +: 2];
               d.pend = BUS_REQ && (h0 || h1);
               d.bank = h1 && !h0;
               d.addr = BUS_ADDR;
               d.wr = BUS_WRITE;
               d.beats = beat_cnt(BUS_SIZE, q.ac[h1 && !h0][AC_PS_LO +: 2]);
            end
         end
         ST_PRE:
         begin
            if (q.cnt != 2'd0)
               d.cnt = q.cnt - 2'd1;
            else if (q.pend)
            begin
               d.pend = 1'b0;
               d.st = ST_ROW;
               d.cnt = {1'b0, cur_ac[AC_RCD]};
            end
            else
               d.st = ST_IDLE;
         end
      endcase

      // pin drive, one cycle behind the sequencer state
      d.ras_n = 2'b11;
      if (q.st == ST_ROW || q.st == ST_COL || q.st == ST_GAP || q.st == ST_HOLD)
         d.ras_n[q.bank] = 1'b0;
      // row strobe lifted one clock early when the row closes after this beat
      if (q.st == ST_COL && q.cnt == 2'd0 && cur_ac[AC_RNCN]
          && cur_ac[AC_CAS_LO +: 2] != 2'd0 && d.st == ST_PRE)
         d.ras_n = 2'b11;
      d.cas_n = (q.st == ST_COL) ? ~lanes : 4'b1111;
      d.ta = (q.st == ST_COL) && (q.cnt == 2'd0);
      d.rw = !((q.st != ST_IDLE) && q.wr);
      d.pins = mux_pins;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         q <= '0;
         q.cfg <= CFG_RST;
         q.ac <= {AC_RST, AC_RST};
         q.mk <= {MK_RST, MK_RST};
         q.st <= ST_IDLE;
         q.ras_n <= 2'b11;
         q.cas_n <= 4'b1111;
         q.rw <= 1'b1;
      end
      else
         q <= d;
   end

   assign PRDATA = q.rdata;
   assign PREADY = q.rdy;
   assign PSLVERR = q.err;
   assign BUS_TA = q.ta;
   assign RAS_N = q.ras_n;
   assign CAS_N = q.cas_n;
   assign DRAM_READ_WRITE_LINE = q.rw;
   assign DRAM_ADDR = q.pins;
endmodule // dbd_ctrl
`default_nettype wire

// *** rtl/dbd_pkg.sv ***
package dbd_pkg;
   // register byte offsets on the APB window
   localparam logic [11:0] OFF_CFG = 12'h100;
   localparam logic [11:0] OFF_AC0 = 12'h108;
   localparam logic [11:0] OFF_MK0 = 12'h10C;
   localparam logic [11:0] OFF_AC1 = 12'h110;
   localparam logic [11:0] OFF_MK1 = 12'h114;
   localparam logic [11:0] OFF_STAT = 12'h118;
   // register select codes
   localparam logic [2:0] SEL_CFG = 3'h0;
   localparam logic [2:0] SEL_AC0 = 3'h1;
   localparam logic [2:0] SEL_MK0 = 3'h2;
   localparam logic [2:0] SEL_AC1 = 3'h3;
   localparam logic [2:0] SEL_MK1 = 3'h4;
   localparam logic [2:0] SEL_STAT = 3'h5;
   localparam logic [2:0] SEL_NONE = 3'h7;
   // configuration register
   localparam int CFG_NAM = 13;
   // address and control register fields
   localparam int AC_BA_HI = 31;
   localparam int AC_BA_LO = 18;
   localparam int AC_RE = 15;
   localparam int AC_CAS_LO = 12;
   localparam int AC_RP_LO = 10;
   localparam int AC_RNCN = 9;
   localparam int AC_RCD = 8;
   localparam int AC_EDO = 6;
   localparam int AC_PS_LO = 4;
   localparam int AC_PM_LO = 2;
   // mask and access control register fields
   localparam int MK_WP = 8;
   localparam int MK_CI = 6;
   localparam int MK_AM = 5;
   localparam int MK_SC = 4;
   localparam int MK_SD = 3;
   localparam int MK_UC = 2;
   localparam int MK_UD = 1;
   localparam int MK_V = 0;
   // writable bits and reset values
   localparam logic [31:0] CFG_WMASK = 32'h0000_2000;
   localparam logic [31:0] AC_WMASK = 32'hFFFC_BF7C;
   localparam logic [31:0] MK_WMASK = 32'hFFFC_017F;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] AC_RST = 32'h0000_0000;
   localparam logic [31:0] MK_RST = 32'h0000_0000;
   // port width select codes
   localparam logic [1:0] PW_32 = 2'b00;
   localparam logic [1:0] PW_8 = 2'b01;
   // page level select codes
   localparam logic [1:0] PG_NONE = 2'b00;
   localparam logic [1:0] PG_BURST = 2'b01;
   localparam logic [1:0] PG_CONT = 2'b11;
   // operand size codes on the internal bus
   localparam logic [1:0] OP_LONG = 2'b00;
   localparam logic [1:0] OP_BYTE = 2'b01;
   localparam logic [1:0] OP_WORD = 2'b10;
   // fixed 512-byte page: page number is address bits 31..9
   localparam int PAGE_LSB = 9;

   typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_GAP, ST_PRE, ST_HOLD} dbd_state_e;
endpackage

// *** testbench/dbd_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module dbd_ctrl_asserts
(
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [31:0] BUS_ADDR,
   input wire logic BUS_WRITE,
   input wire logic BUS_TA,
   input wire logic [1:0] RAS_N,
   input wire logic [3:0] CAS_N,
   input wire logic DRAM_READ_WRITE_LINE,
   input wire logic [31:0] DRAM_ADDR
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   sequence row_open;
      $fell(RAS_N[0]);
   endsequence
   sequence col_open;
      $fell(CAS_N[0]);
   endsequence
   AST_APB_ANSWER: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("apb answer late");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_TA_IN_CAS: assert property (BUS_TA |-> CAS_N != 4'hF)
      else $error("termination outside column strobe");
   AST_TA_PULSE: assert property (BUS_TA |=> !BUS_TA)
      else $error("termination longer than one cycle");
   AST_ROW_TERM: assert property (row_open |-> ##[1:5] BUS_TA)
      else $error("row cycle not terminated");
   AST_ROW_ADDR: assert property (row_open |-> DRAM_ADDR[31:9] == BUS_ADDR[31:9])
      else $error("row address wrong");
   AST_COL_KEEP: assert property (row_open ##[1:2] col_open |->
      $stable({DRAM_ADDR[31:26], DRAM_ADDR[8:0]})) else $error("fixed pins moved");
   AST_CAS_UNDER_RAS: assert property (col_open |-> RAS_N != 2'b11)
      else $error("column strobe without row");
   AST_RW_LINE: assert property (row_open |-> DRAM_READ_WRITE_LINE == !BUS_WRITE)
      else $error("read write line wrong");
endmodule // dbd_ctrl_asserts
bind dbd_ctrl dbd_ctrl_asserts i_asserts (.SYS_CLK, .SRST, .PSEL, .PENABLE, .PREADY,
   .PSLVERR, .BUS_ADDR, .BUS_WRITE, .BUS_TA, .RAS_N, .CAS_N, .DRAM_READ_WRITE_LINE,
   .DRAM_ADDR);
`default_nettype wire

// *** testbench/dbd_dram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dbd_dram_model
(
   input wire logic clk,
   input wire logic clr,
   input wire logic [1:0] ras_n,
   input wire logic [3:0] cas_n,
   input wire logic [31:0] addr,
   output logic [31:0] row_q,
   output logic [31:0] col_q
);
   logic ras_p = 1;
   logic cas_p = 1;
   logic rowed = 0;
   logic got = 0;
   // keeps only the first row and column of an access, later beats and row opens are ignored
   always @(posedge clk)
   begin
      ras_p <= &ras_n;
      cas_p <= cas_n[0];
      if (clr)
      begin
         rowed <= 0;
         got <= 0;
      end
      else if (ras_p && !(&ras_n) && !rowed)
      begin
         row_q <= addr;
         rowed <= 1;
      end
      else if (rowed && cas_p && !cas_n[0] && !got)
      begin
         col_q <= addr;
         got <= 1;
      end
   end
endmodule // dbd_dram_model
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dbd_pkg::*;
   logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic bus_req = 0, bus_write = 0, nxt_v = 0, clr = 0, pready, pslverr, bus_ta, rwl;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, a, nxt = '0, bus_addr = '0, prdata, dram_addr, row, col;
   logic [31:0] lf = 32'h0000_0003;
   logic [1:0] bus_size = '0, sz, ras_n;
   logic [3:0] cas_n, typ = '0;
   logic [3:0] tt [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
   int n_mismatch = 0, tests_run = 0, cyc = 0, n, nr, n1;
   dbd_ctrl i_dut (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BUS_REQ(bus_req), .BUS_ADDR(bus_addr), .BUS_WRITE(bus_write),
      .BUS_SIZE(bus_size), .BUS_CPU_SPACE(typ[3]), .BUS_ALT_MASTER(typ[2]),
      .BUS_SUPERVISOR(typ[1]), .BUS_CODE(typ[0]), .BUS_NEXT_VALID(nxt_v),
      .BUS_NEXT_ADDR(nxt), .BUS_TA(bus_ta), .RAS_N(ras_n), .CAS_N(cas_n),
      .DRAM_READ_WRITE_LINE(rwl), .DRAM_ADDR(dram_addr));
   dbd_dram_model i_mem (.clk(sys_clk), .clr(clr), .ras_n(ras_n), .cas_n(cas_n),
      .addr(dram_addr), .row_q(row), .col_q(col));
   initial forever #2.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfn(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] cmap(logic [31:0] v, logic bp);
      logic [31:0] p;
      p = v;
      for (int i = 9; i <= 16; i++) p[i] = v[17-i];
      p[17] = bp ? v[0] : v[16];
      for (int i = 18; i <= 25; i++) p[i] = v[i-1];
      return p;
   endfunction
   function automatic int beats(logic [1:0] pw, logic [1:0] s);
      int pb, ob;
      pb = (pw == PW_32) ? 4 : (pw == PW_8) ? 1 : 2;
      ob = (s == OP_BYTE) ? 1 : (s == OP_WORD) ? 2 : (s == OP_LONG) ? 4 : 16;
      return (ob > pb) ? ob / pb : 1;
   endfunction
   // page modes open the row once per access, the others once per beat
   function automatic int rows(logic [1:0] pm, int b);
      return (pm == PG_BURST || pm == PG_CONT) ? 1 : b;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // a miss gives no answer at all, so a fixed window is counted;
   // 180 cycles cover sixteen nonpage beats at the slowest strobe timing
   task automatic acc(logic [31:0] ad, logic w, logic [1:0] s, logic [3:0] t);
      logic [1:0] rp;
      @(posedge sys_clk);
      bus_req <= 1;
      bus_addr <= ad;
      bus_write <= w;
      bus_size <= s;
      typ <= t;
      clr <= 1;
      @(posedge sys_clk);
      bus_req <= 0;
      clr <= 0;
      n = 0;
      nr = 0;
      n1 = 0;
      rp = ras_n;
      repeat (180)
      begin
         @(posedge sys_clk);
         if (bus_ta === 1'b1) n++;
         if (rp[0] === 1'b1 && ras_n[0] === 1'b0) nr++;
         if (rp[1] === 1'b1 && ras_n[1] === 1'b0) n1++;
         rp = ras_n;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run;
      end
   end
   initial
   begin
      repeat (3) @(posedge sys_clk);
      srst <= 0;
      apb(0, OFF_MK0, 0);
      chk("mk0 reset", MK_RST, rd);
      apb(0, 12'h1F0, 0);
      chk("unmapped err", 1, 32'(er));
      chk("unmapped data", 0, rd);
      apb(1, OFF_MK1, 32'hFFFF_FFFF);
      apb(0, OFF_MK1, 0);
      chk("mk1 rw", MK_WMASK, rd);
      acc(0, 0, OP_LONG, 0);
      chk("no valid", 0, 32'(n));
      for (int i = 0; i < 16; i++)
      begin
         lf = lfn(lf);
         // random cas, precharge, early row lift and row-to-column delay
         apb(1, OFF_AC0, {lf[31:18], 4'h0, lf[13:8], 2'b00, 2'(i), 2'(i >> 2), 2'b00});
         apb(1, OFF_MK0, 32'h0000_0001);
         sz = lf[5:4];
         // lines stay 16-byte aligned so a burst never leaves its page
         a = {lf[31:4], (sz == 2'b11) ? 2'b00 : lf[3:2],
              (sz == OP_BYTE || i == 1) ? lf[1:0] | 2'(i == 1) : 2'b00};
         if (i == 1) sz = OP_BYTE;
         acc(a, lf[6], sz, 0);
         chk("beats", 32'(beats(2'(i), sz)), 32'(n));
         chk("row opens", 32'(rows(2'(i >> 2), beats(2'(i), sz))), 32'(nr));
         chk("row", a, row);
         chk("col", cmap(a, 2'(i) == PW_8), col);
      end
      apb(1, OFF_AC0, 32'h4004_0000);
      apb(1, OFF_MK0, 32'h8000_0001);
      acc(32'hC004_0000, 0, OP_LONG, 0);
      chk("masked bit", 1, 32'(n));
      acc(32'h4014_0000, 0, OP_LONG, 0);
      chk("compared bit", 0, 32'(n));
      apb(1, OFF_MK0, 32'h0000_0101);
      acc(32'h4004_0010, 1, OP_LONG, 0);
      chk("wp write", 0, 32'(n));
      acc(32'h4004_0010, 0, OP_LONG, 0);
      chk("wp read", 1, 32'(n));
      for (int k = 0; k < 6; k++)
      begin
         apb(1, OFF_MK0, 32'h0000_0001 | (32'h0000_0002 << k));
         acc(32'h4004_0020, 0, OP_LONG, tt[k]);
         chk("type off", 0, 32'(n));
         acc(32'h4004_0020, 0, OP_LONG, tt[(k + 1) % 6]);
         chk("type on", 1, 32'(n));
      end
      // continuous page: a same-page follow-up keeps the row, a miss reopens it
      apb(1, OFF_AC0, 32'h4004_000C);
      apb(1, OFF_MK0, 32'h0000_0001);
      nxt <= 32'h4004_0040;
      nxt_v <= 1;
      acc(32'h4004_0000, 0, OP_LONG, 0);
      chk("hold first ta", 1, 32'(n));
      chk("hold first rows", 1, 32'(nr));
      acc(32'h4004_0040, 0, OP_LONG, 0);
      chk("hold hit ta", 1, 32'(n));
      chk("hold hit rows", 0, 32'(nr));
      acc(32'h4004_0200, 0, OP_LONG, 0);
      chk("hold miss ta", 1, 32'(n));
      chk("hold miss rows", 1, 32'(nr));
      nxt_v <= 0;
      apb(1, OFF_AC1, 32'h8000_0000);
      apb(1, OFF_MK1, 32'h0000_0001);
      acc(32'h8000_0010, 1, OP_LONG, 0);
      chk("bank1 ta", 1, 32'(n));
      chk("bank1 rows", 1, 32'(n1));
      chk("bank0 rows", 0, 32'(nr));
      chk("bank1 row", 32'h8000_0010, row);
      apb(1, OFF_CFG, CFG_WMASK);
      acc(32'h4004_0124, 0, OP_LONG, 0);
      chk("no mux", 32'h4004_0124, col);
      complete_run;
   end
endmodule // tb
`default_nettype wire
